// ===== common/ils_pkg.sv
// Purpose: constants for the input link half swap stage
// Assumes: sixteen links of twenty data bits plus one sync bit
// Notes:   mask bit i of a group stands for link (group base + i)
package ils_pkg;
	localparam int NUM_LINKS  = 16;
	localparam int DATA_BITS  = 20;
	localparam int HALF_BITS  = 10;
	localparam int LINK_W     = 21;
	localparam int SYNC_BIT   = 20;
	localparam int GROUP_W    = 8;
	localparam int UPPER_BASE = 8;
	localparam int POS_COUNT  = 4;
	localparam int POS_W      = 2;
	localparam int FIFO_DEPTH = 4;
	localparam int BUS_W      = NUM_LINKS * LINK_W;

	// board wiring swap masks, index 0..3 for board positions 1..4
	localparam logic [7:0] WIRE_UP  [POS_COUNT] =
		'{8'hF4, 8'h82, 8'h20, 8'h02};
	localparam logic [7:0] WIRE_LOW [POS_COUNT] =
		'{8'hD0, 8'hE2, 8'hF0, 8'hD2};
	// left_hand_board correction masks of the front_end_digitizer_board
	localparam logic [7:0] CORR_UP  [POS_COUNT] =
		'{8'h9E, 8'h87, 8'hB3, 8'hD2};
	localparam logic [7:0] CORR_LOW [POS_COUNT] =
		'{8'h86, 8'h64, 8'h54, 8'h94};

	localparam logic [POS_W-1:0] POS_RST = 2'h0;
endpackage : ils_pkg

// ===== rtl/ils_fifo.sv
// Purpose: small word FIFO with valid/ready on both sides
// Assumes: one clock, depth of at least two
// Notes:   ready and valid come from flops to keep paths short
`timescale 1ns/1ns
`default_nettype none
module ils_fifo #(
	parameter int WIDTH = 336,
	parameter int DEPTH = 4
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             sys_rst,
	// fill side
	input  wire logic             wrValid,
	output logic                  wrReady,
	input  wire logic [WIDTH-1:0] wrData,
	// drain side
	output logic                  rdValid,
	input  wire logic             rdReady,
	output logic      [WIDTH-1:0] rdData
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
	logic [CW-1:0]    count_r, count_nxt;
	logic             rdy_r, rdy_nxt, vld_r, vld_nxt;
	logic             push, pop;

	assign push    = wrValid && rdy_r;
	assign pop     = vld_r && rdReady;
	assign wrReady = rdy_r;
	assign rdValid = vld_r;
	assign rdData  = mem[rdPtr_r];

	always_comb
	begin
		wrPtr_nxt = wrPtr_r;
		rdPtr_nxt = rdPtr_r;
		count_nxt = count_r;
		if (push)
			wrPtr_nxt = (wrPtr_r == LAST_PTR) ? '0 : wrPtr_r + 1'b1;
		if (pop)
			rdPtr_nxt = (rdPtr_r == LAST_PTR) ? '0 : rdPtr_r + 1'b1;
		if (push && !pop)
			count_nxt = count_r + 1'b1;
		else if (pop && !push)
			count_nxt = count_r - 1'b1;
		rdy_nxt = (count_nxt != FULL_CNT);
		vld_nxt = (count_nxt != '0);
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
			rdy_r   <= 1'b0;
			vld_r   <= 1'b0;
		end
		else
		begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
			count_r <= count_nxt;
			rdy_r   <= rdy_nxt;
			vld_r   <= vld_nxt;
		end
	end

	// storage needs no reset; validity is tracked by the count
	always_ff @(posedge clk_sys)
	begin
		if (push)
			mem[wrPtr_r] <= wrData;
	end
endmodule : ils_fifo
`default_nettype wire

// ===== rtl/ils_half_swap.sv
// Purpose: per-link half word swap of deserialized input links
// Assumes: boardPos is static, synchronous to clk_sys
// Notes:   swap is applied at FIFO entry, ahead of any multiplexing
//
// Overview of operation
// RQ1: position one swaps upper links 14,13,11,9 (0x6A), lower 6,4,2,1 (0x56).
// RQ2: position two swaps upper links 10,8 (0x05), lower 7,2,1 (0x86).
// RQ3: position three swaps upper 15,12,9,8 (0x93), lower 7,5,2 (0xA4).
// RQ4: position four swaps upper 15,14,12 (0xD0), lower 6,2,1 (0x46).
// RQ5: effective mask is wiring mask XOR left_hand_board correction mask.
// RQ6: swap exchanges low and high ten data bits; sync bit stays put.
// RQ7: swap happens on input data before any downstream multiplexing.
// RQ8: swapping depends on link index and board position.
// RQ9: mask MSB is highest link of group, LSB is lowest.
`timescale 1ns/1ns
`default_nettype none
module ils_half_swap #(
	parameter int DEPTH = ils_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	// board position within the sector, 0..3 for boards 1..4
	input  wire logic [ils_pkg::POS_W-1:0] boardPos,
	// deserialized links, link k at bits [k*21 +: 21]
	input  wire logic                      inValid,
	output logic                           inReady,
	input  wire logic [ils_pkg::BUS_W-1:0] inData,
	// swapped links toward the multiplexer
	output logic                           outValid,
	input  wire logic                      outReady,
	output logic      [ils_pkg::BUS_W-1:0] outData
);
	import ils_pkg::*;

	logic [POS_W-1:0]     pos_r, pos_nxt;
	logic [GROUP_W-1:0]   upMask, lowMask;
	logic [NUM_LINKS-1:0] effMask;
	logic [BUS_W-1:0]     swapData;
	logic                 fifoValid, fifoReady, fifoTake;
	logic [BUS_W-1:0]     fifoData;
	logic                 outValid_r, outValid_nxt;
	logic [BUS_W-1:0]     outData_r, outData_nxt;

	// wiring and correction cancel where both apply [RQ5]
	// table indexed by board position [RQ8] [RQ1] [RQ2] [RQ3] [RQ4]
	assign upMask  = WIRE_UP[pos_r] ^ CORR_UP[pos_r];
	assign lowMask = WIRE_LOW[pos_r] ^ CORR_LOW[pos_r];
	// mask bit i of a group drives link base+i [RQ9]
	assign effMask = {upMask, lowMask};

	// one swap unit per link [RQ8]
	genvar k;
	generate
		for (k = 0; k < NUM_LINKS; k++)
		begin : g_link
			logic [LINK_W-1:0] raw;
			assign raw = inData[k*LINK_W +: LINK_W];
			// halves exchanged, sync bit passes untouched [RQ6]
			assign swapData[k*LINK_W +: LINK_W] = effMask[k] ?
				{raw[SYNC_BIT], raw[HALF_BITS-1:0],
				 raw[DATA_BITS-1:HALF_BITS]} : raw;
		end
	endgenerate

	// registered so one word never sees a mask split between positions;
	// costs one cycle of lag, so hold boardPos steady before traffic
	always_comb
	begin
		pos_nxt = boardPos;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
			pos_r <= POS_RST;
		else
			pos_r <= pos_nxt;
	end

	// swapped words enter the buffer; nothing unswapped goes past [RQ7]
	ils_fifo #(
		.WIDTH (BUS_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clk_sys (clk_sys),
		.sys_rst (sys_rst),
		.wrValid (inValid),
		.wrReady (fifoReady),
		.wrData  (swapData),
		.rdValid (fifoValid),
		.rdReady (fifoTake),
		.rdData  (fifoData)
	);

	assign inReady = fifoReady;

	// output register; downstream stall backs up into the FIFO
	assign fifoTake = !outValid_r || outReady;

	always_comb
	begin
		outValid_nxt = outValid_r;
		outData_nxt  = outData_r;
		if (fifoTake)
		begin
			outValid_nxt = fifoValid;
			if (fifoValid)
				outData_nxt = fifoData;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			outValid_r <= 1'b0;
			outData_r  <= '0;
		end
		else
		begin
			outValid_r <= outValid_nxt;
			outData_r  <= outData_nxt;
		end
	end

	assign outValid = outValid_r;
	assign outData  = outData_r;

	// checks

	// taps on the lowest, second and highest link
	logic [LINK_W-1:0] link0In, link0Sw, link15In, link15Sw;
	logic [LINK_W-1:0] link1In, link1Sw;
	assign link0In  = inData[0 +: LINK_W];
	assign link0Sw  = swapData[0 +: LINK_W];
	assign link1In  = inData[LINK_W +: LINK_W];
	assign link1Sw  = swapData[LINK_W +: LINK_W];
	assign link15In = inData[15*LINK_W +: LINK_W];
	assign link15Sw = swapData[15*LINK_W +: LINK_W];

	// position as registered, one cycle behind boardPos
	sequence s_pos(logic [POS_W-1:0] p);
		pos_r == p;
	endsequence

	a_mask_pos1: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ1]
		s_pos(2'h0) |-> effMask == 16'h6A56)
		else $error("position one mask wrong");

	a_mask_pos2: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ2]
		s_pos(2'h1) |-> effMask == 16'h0586)
		else $error("position two mask wrong");

	a_mask_pos3: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ3]
		s_pos(2'h2) |-> effMask == 16'h93A4)
		else $error("position three mask wrong");

	a_mask_pos4: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ4]
		s_pos(2'h3) |-> effMask == 16'hD046)
		else $error("position four mask wrong");

	a_mask_xor: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ5]
		(WIRE_UP[pos_r][5] && CORR_UP[pos_r][5]) |-> !effMask[13])
		else $error("double correction not cancelled");

	a_half_swap: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ6]
		effMask[15] |-> link15Sw[HALF_BITS-1:0] ==
			link15In[DATA_BITS-1:HALF_BITS] &&
			link15Sw[DATA_BITS-1:HALF_BITS] == link15In[HALF_BITS-1:0])
		else $error("link 15 halves not exchanged");

	a_sync_kept: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ6]
		link0Sw[SYNC_BIT] == link0In[SYNC_BIT] &&
		link15Sw[SYNC_BIT] == link15In[SYNC_BIT])
		else $error("sync bit disturbed");

	a_no_swap: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ8]
		!effMask[0] |-> link0Sw == link0In)
		else $error("unswapped link altered");

	a_low_swap: assert property (@(posedge clk_sys) // [RQ6]
		disable iff (sys_rst)
		effMask[1] |-> link1Sw[HALF_BITS-1:0] ==
			link1In[DATA_BITS-1:HALF_BITS] &&
			link1Sw[DATA_BITS-1:HALF_BITS] == link1In[HALF_BITS-1:0] &&
			link1Sw[SYNC_BIT] == link1In[SYNC_BIT])
		else $error("link 1 halves not exchanged");

	a_upper_keep: assert property (@(posedge clk_sys) // [RQ8]
		disable iff (sys_rst)
		!effMask[15] |-> link15Sw == link15In)
		else $error("unswapped upper link altered");

	a_pos_follow: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ8]
		##1 pos_r == $past(boardPos))
		else $error("board position not tracked");

	a_mask_order: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ9]
		effMask[15:8] == upMask && effMask[7:0] == lowMask)
		else $error("mask bit order wrong");

	sequence s_stalled;
		outValid_r && !outReady;
	endsequence

	a_out_hold: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RQ7]
		s_stalled |=> outValid_r && $stable(outData_r))
		else $error("output changed while stalled");

	// output valid is high two edges after a word is taken, stall or not
	sequence s_take;
		inValid && inReady;
	endsequence

	a_pass_latency: assert property (@(posedge clk_sys) // [RQ7]
		disable iff (sys_rst)
		s_take |-> ##2 outValid_r)
		else $error("taken word never reached the output");

	// once drained, output valid falls instead of repeating a word
	a_out_drop: assert property (@(posedge clk_sys) // [RQ7]
		disable iff (sys_rst)
		outValid_r && outReady && !fifoValid |=> !outValid_r)
		else $error("output word repeated");
endmodule : ils_half_swap
`default_nettype wire

// ===== verification/ils_src_model.sv
// Purpose: front end board model feeding deserialized link words
// Assumes: stage takes a word at a rising edge with inReady high
// Notes:   lines invert after release so stale data never matches
`timescale 1ns/1ns
`default_nettype none
module ils_src_model
	import ils_pkg::*;
(
	// clock and handshake
	input  wire logic                      clk_sys,
	input  wire logic                      inReady,
	// word toward the stage
	output logic                           inValid,
	output logic      [ils_pkg::BUS_W-1:0] inData
);
	initial
	begin
		inValid = 1'b0;
		inData  = '0;
	end
	// word and valid held until taken
	task automatic put(input logic [BUS_W-1:0] d);
		@(negedge clk_sys);
		inValid = 1'b1;
		inData  = d;
		do @(posedge clk_sys); while (inReady !== 1'b1);
	endtask : put
	task automatic idle;
		@(negedge clk_sys);
		inValid = 1'b0;
		inData  = ~inData;
	endtask : idle
endmodule : ils_src_model
`default_nettype wire

// ===== verification/test_input_link_half_swap.sv
// Purpose: self-checking bench for the half swap stage
// Assumes: source model holds each word until taken
// Notes:   expected words built from wiring and correction masks
`timescale 1ns/1ns
`default_nettype none
module test_input_link_half_swap;
	import ils_pkg::*;
	logic             clk_sys  = 1'b0;
	logic             sys_rst  = 1'b1;
	logic [POS_W-1:0] boardPos = 2'h0;
	logic             outReady = 1'b1;
	logic             inValid;
	logic             inReady;
	logic             outValid;
	logic [BUS_W-1:0] inData;
	logic [BUS_W-1:0] outData;
	logic [BUS_W-1:0] got [$];
	int               fails     = 0;
	int               cmp_count = 0;
	int               cycles    = 0;
	logic [15:0] wireM [4] = '{16'hF4D0, 16'h82E2, 16'h20F0, 16'h02D2};
	logic [15:0] corrM [4] = '{16'h9E86, 16'h8764, 16'hB354, 16'hD294};
	always #2 clk_sys = ~clk_sys;
	ils_src_model u_src (.clk_sys(clk_sys), .inReady(inReady),
		.inValid(inValid), .inData(inData));
	ils_half_swap u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.boardPos(boardPos), .inValid(inValid), .inReady(inReady),
		.inData(inData), .outValid(outValid), .outReady(outReady),
		.outData(outData));
	// whole run needs well under a thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (outValid === 1'b1 && outReady === 1'b1)
			got.push_back(outData);
		if (cycles == 5000)
		begin
			fails++;
			end_sim();
		end
	end
	function automatic logic [BUS_W-1:0] pat(input int s);
		logic [BUS_W-1:0] d;
		for (int k = 0; k < NUM_LINKS; k++)
			d[k*LINK_W +: LINK_W] = {1'(k + s), 10'(s * 37 + k), 10'(k * 11 + 5)};
		return d;
	endfunction : pat
	function automatic logic [BUS_W-1:0] swp(input logic [BUS_W-1:0] d,
		input int p);
		logic [15:0] m;
		m = wireM[p] ^ corrM[p];
		for (int k = 0; k < NUM_LINKS; k++)
			if (m[k])
				d[k*LINK_W +: LINK_W] = {d[k*LINK_W+20], d[k*LINK_W +: 10],
					d[k*LINK_W+10 +: 10]};
		return d;
	endfunction : swp
	task automatic chk(input string what, input logic [BUS_W-1:0] seen,
		input logic [BUS_W-1:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic take(input int s, input int p);
		logic [BUS_W-1:0] w;
		for (int i = 0; i < 50 && got.size() == 0; i++)
			@(posedge clk_sys);
		w = 'x;
		if (got.size() > 0)
			w = got.pop_front();
		chk("outData", w, swp(pat(s), p));
	endtask : take
	// each board position with the same link indices
	task automatic t_pos;
		for (int p = 0; p < POS_COUNT; p++)
		begin
			@(negedge clk_sys);
			boardPos = POS_W'(p);
			repeat (2) @(negedge clk_sys);
			u_src.put(pat(p));
			u_src.idle();
			take(p, p);
		end
	endtask : t_pos
	// stall the sink, fill until refused, drain in order
	task automatic t_fill;
		int n;
		n = 0;
		@(negedge clk_sys);
		outReady = 1'b0;
		while (n < 8)
		begin
			u_src.put(pat(20 + n));
			n++;
			#1;
			if (inReady !== 1'b1)
				break;
		end
		u_src.idle();
		chk("inReady", BUS_W'(inReady), BUS_W'(1'b0));
		// four buffered words plus the one parked in the output register
		chk("depth", BUS_W'(n), BUS_W'(FIFO_DEPTH + 1));
		repeat (4) @(negedge clk_sys);
		outReady = 1'b1;
		for (int i = 0; i < n; i++)
			take(20 + i, POS_COUNT - 1);
		repeat (3) @(negedge clk_sys);
		chk("extra words", BUS_W'(got.size()), BUS_W'(0));
		chk("outValid", BUS_W'(outValid), BUS_W'(1'b0));
	endtask : t_fill
	task automatic end_sim;
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		t_pos();
		t_fill();
		end_sim();
	end
endmodule : test_input_link_half_swap
`default_nettype wire
